/* File: rtl/sos_defs.svh */
// Register offsets, reset values and limits of the status output selector
`ifndef SOS_DEFS_SVH
`define SOS_DEFS_SVH
// Register word offsets on the register port
`define SOS_OFS_SEL_BASE 5'h00
`define SOS_OFS_DET_FREQ 5'h08
`define SOS_OFS_DET_BAND 5'h09
`define SOS_OFS_MAX_FREQ 5'h0A
`define SOS_OFS_STALL_LEVEL 5'h0B
`define SOS_OFS_OL_LEVEL 5'h0C
`define SOS_OFS_MOTOR_RATED 5'h0D
`define SOS_OFS_STALL_DC 5'h0E
`define SOS_OFS_OH_LIMIT 5'h0F
`define SOS_OFS_ESTOP_CFG 5'h10
`define SOS_OFS_STATUS 5'h11
`define SOS_OFS_ITEMS 5'h12
// Field positions
`define SOS_ESTOP_EN_BIT 4
`define SOS_STATUS_ESTOP_BIT 8
// Reset selections of the eight outputs
`define SOS_RST_SEL1 5'h11
`define SOS_RST_SEL2 5'h13
`define SOS_RST_SEL3 5'h14
`define SOS_RST_SEL4 5'h0D
`define SOS_RST_SEL5 5'h12
`define SOS_RST_SEL6 5'h00
`define SOS_RST_SEL7 5'h00
`define SOS_RST_SEL8 5'h00
// Reset values of the setting registers
`define SOS_RST_DET_FREQ 16'h0000
`define SOS_RST_DET_BAND 16'h0000
`define SOS_RST_MAX_FREQ 16'h1770
`define SOS_RST_STALL_LEVEL 8'h64
`define SOS_RST_OL_LEVEL 16'hFFFF
`define SOS_RST_MOTOR_RATED 16'h0064
`define SOS_RST_STALL_DC 16'hFFFF
`define SOS_RST_OH_LIMIT 16'hFFFF
`define SOS_RST_ESTOP_CFG 5'h00
// Stall level limits in percent and the percent scale
`define SOS_STALL_MIN 8'h1E
`define SOS_STALL_MAX 8'h96
`define SOS_PCT_SCALE 24'h000064
// Number of input terminals that can carry the emergency stop
`define SOS_TERM_COUNT 4'hF
`endif

/* File: rtl/sos_pkg.sv */
// Types shared by the status output selector modules
package sos_pkg;

	// Status items that an auxiliary output can show
	typedef enum logic [4:0] {
		ITEM_NONE = 5'h00,
		ITEM_CMD_REACHED = 5'h01,
		ITEM_TARGET_REACHED = 5'h02,
		ITEM_FREQ_MATCH = 5'h03,
		ITEM_ABOVE = 5'h04,
		ITEM_BELOW = 5'h05,
		ITEM_OL_WARN = 5'h06,
		ITEM_DRIVE_OL = 5'h07,
		ITEM_STALL = 5'h08,
		ITEM_LINK_OV = 5'h09,
		ITEM_UNDERVOLT = 5'h0A,
		ITEM_OVERHEAT = 5'h0B,
		ITEM_LOST_CMD = 5'h0C,
		ITEM_RUN = 5'h0D,
		ITEM_STOP = 5'h0E,
		ITEM_STEADY = 5'h0F,
		ITEM_SPEED_SEARCH = 5'h10,
		ITEM_READY = 5'h11,
		ITEM_WARNING = 5'h12,
		ITEM_FAN_RUN = 5'h13,
		ITEM_NORMAL = 5'h14,
		ITEM_OVERCURRENT = 5'h15,
		ITEM_MV_RUN = 5'h16
	} sos_item_t;

	// Frequency, current and voltage values share one width
	typedef logic [15:0] sos_value_t;

	// One bit per item code
	typedef logic [22:0] sos_items_t;

endpackage : sos_pkg

/* File: rtl/sos_item_if.sv */
// Item vector carried from the item logic to the output selectors
`timescale 1ns/100ps
`default_nettype none
interface sos_item_if;
	import sos_pkg::*;
	sos_items_t item;
	// Producer of the items
	modport src (output item);
	// Consumer that picks one item
	modport snk (input item);
endinterface : sos_item_if
`default_nettype wire

/* File: rtl/sos_freq_cmp.sv */
// Five frequency detection comparisons sharing one frequency and band
`timescale 1ns/100ps
`default_nettype none
module sos_freq_cmp
	import sos_pkg::*;
(
	// Frequencies in one common unit
	input wire sos_value_t cmd_freq_i,
	input wire sos_value_t out_freq_i,
	input wire sos_value_t det_freq_i,
	input wire sos_value_t det_band_i,
	// Deceleration selects the lowered threshold
	input wire logic decel_i,
	// Detection results
	output logic cmd_reached_o,
	output logic target_reached_o,
	output logic match_o,
	output logic above_o,
	output logic below_o
);
	sos_value_t err_cmd;
	sos_value_t err_det;
	logic [17:0] out_x2_band;
	logic [17:0] det_x2;

	// Doubling the error avoids losing the odd half of the band
	assign err_cmd = (cmd_freq_i > out_freq_i) ? cmd_freq_i - out_freq_i : out_freq_i - cmd_freq_i;
	assign err_det = (det_freq_i > out_freq_i) ? det_freq_i - out_freq_i : out_freq_i - det_freq_i;
	assign out_x2_band = {1'b0, out_freq_i, 1'b0} + {2'h0, det_band_i};
	assign det_x2 = {1'b0, det_freq_i, 1'b0};

	// Window comparisons
	assign cmd_reached_o = {err_cmd, 1'b0} <= {1'b0, det_band_i};
	assign match_o = {err_det, 1'b0} <= {1'b0, det_band_i};
	assign target_reached_o = cmd_reached_o && match_o;

	// Threshold comparisons, lowered by half the band while slowing down
	assign above_o = decel_i ? (out_x2_band > det_x2) : (out_freq_i >= det_freq_i);
	assign below_o = decel_i ? (out_x2_band < det_x2) : (out_freq_i <= det_freq_i);

endmodule : sos_freq_cmp
`default_nettype wire

/* File: rtl/sos_aux_out.sv */
// One auxiliary contact output that shows the selected item
`timescale 1ns/100ps
`default_nettype none
module sos_aux_out
	import sos_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// Selection and item vector
	input wire logic [4:0] sel_i,
	sos_item_if.snk items,
	// Contact drive
	output logic aux_o
);
	// Codes past the last item act like none
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			aux_o <= 1'b0;
		end else if (sel_i == ITEM_NONE || sel_i > ITEM_MV_RUN) begin
			aux_o <= 1'b0;
		end else begin
			aux_o <= items.item[sel_i];
		end
	end
endmodule : sos_aux_out
`default_nettype wire

/* File: rtl/sos_top.sv */
// Status output selector: eight auxiliary contacts driven from drive status
// Function
// - Eight outputs, own select each, none stays off
// - Reset selects ready, fan, normal, run, warning
// - Command reached within half the band
// - Target reached needs command reached and match
// - Match: detect frequency within half band
// - Above: accel at least, decel above lowered
// - Below: accel at most, decel below lowered
// - Detect frequency, band limited to maximum frequency
// - Overload warning: running and current above level
// - Drive overload and overcurrent faults shown
// - Link overvoltage and input undervoltage shown
// - Overheat when cell temperature exceeds limit
// - Stall item: stall prevention while running
// - Stall by current, by link volts decelerating
// - Stall level 30 to 150 percent, default 100
// - Lost command item follows command loss
// - Run held off during braking and bypass
// - Stop, steady and speed search items
// - Ready follows control power, fan follows HV
// - Warning from transformer heat or door open
// - Normal: cell link healthy and drive operable
// - MV run stays on through bypass switchover
// - Assignable input terminal acts as emergency stop
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "sos_defs.svh"
module sos_top
	import sos_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// Register port
	input wire logic [4:0] addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	output logic [31:0] rd_data_o,
	// Measured values from the drive control
	input wire sos_value_t cmd_freq_i,
	input wire sos_value_t out_freq_i,
	input wire sos_value_t out_current_i,
	input wire sos_value_t cell_dc_volt_i,
	input wire sos_value_t cell_temp_i,
	// Operating state from the drive control
	input wire logic running_i,
	input wire logic accel_i,
	input wire logic decel_i,
	input wire logic dc_brake_i,
	input wire logic bypass_switch_i,
	input wire logic speed_search_active_i,
	input wire logic lost_cmd_i,
	// Faults and warnings from the drive control
	input wire logic drive_overload_i,
	input wire logic overcurrent_fault_i,
	input wire logic link_overvoltage_i,
	input wire logic input_undervoltage_fault_i,
	input wire logic transformer_overheat_warning_i,
	input wire logic door_open_warning_i,
	// Power and cell link state
	input wire logic control_power_i,
	input wire logic hv_power_i,
	input wire logic cell_link_ok_i,
	input wire logic operable_i,
	// Multi-function input terminals from pins
	input wire logic [14:0] mfi_i,
	// Contact outputs and emergency stop
	output logic [7:0] aux_o,
	output logic emergency_stop_o
);
	localparam logic [4:0] RST_SEL [8] = '{`SOS_RST_SEL1, `SOS_RST_SEL2, `SOS_RST_SEL3,
		`SOS_RST_SEL4, `SOS_RST_SEL5, `SOS_RST_SEL6, `SOS_RST_SEL7, `SOS_RST_SEL8};

	// Settings
	logic [4:0] sel [8];
	sos_value_t detect_frequency;
	sos_value_t detect_bandwidth;
	sos_value_t max_freq;
	logic [7:0] stall_level;
	sos_value_t ol_level;
	sos_value_t motor_rated;
	sos_value_t stall_dc_limit;
	sos_value_t oh_limit;
	logic [4:0] estop_cfg;
	// Registered inputs
	sos_value_t q_cmd;
	sos_value_t q_out;
	sos_value_t q_cur;
	sos_value_t q_dc;
	sos_value_t q_temp;
	logic q_running;
	logic q_accel;
	logic q_decel;
	logic q_brake;
	logic q_bypass;
	logic q_search;
	logic q_lost;
	logic q_iol;
	logic q_oct;
	logic q_ov;
	logic q_uv;
	logic q_tohw;
	logic q_door;
	logic q_ctrl_pwr;
	logic q_hv;
	logic q_link_ok;
	logic q_operable;
	// Pin synchroniser
	logic [14:0] mfi_meta;
	logic [14:0] mfi_sync;
	// Derived terms
	logic fd_cmd;
	logic fd_target;
	logic fd_match;
	logic fd_above;
	logic fd_below;
	logic stall_active;
	logic [23:0] cur_pct;
	logic [23:0] stall_limit;
	sos_value_t wr_value;
	logic [7:0] wr_stall;
	logic [31:0] next_rd_data;

	sos_item_if items ();

	////////////////////////////////////////////////////////////////////////////////
	// Input stage

	// All status sampled once so every item sees one coherent snapshot
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			q_cmd <= 16'h0000;
			q_out <= 16'h0000;
			q_cur <= 16'h0000;
			q_dc <= 16'h0000;
			q_temp <= 16'h0000;
			{q_running, q_accel, q_decel, q_brake, q_bypass, q_search, q_lost} <= 7'h00;
			{q_iol, q_oct, q_ov, q_uv, q_tohw, q_door} <= 6'h00;
			{q_ctrl_pwr, q_hv, q_link_ok, q_operable} <= 4'h0;
		end else begin
			q_cmd <= cmd_freq_i;
			q_out <= out_freq_i;
			q_cur <= out_current_i;
			q_dc <= cell_dc_volt_i;
			q_temp <= cell_temp_i;
			{q_running, q_accel, q_decel, q_brake} <= {running_i, accel_i, decel_i, dc_brake_i};
			{q_bypass, q_search, q_lost} <= {bypass_switch_i, speed_search_active_i, lost_cmd_i};
			{q_iol, q_oct, q_ov} <= {drive_overload_i, overcurrent_fault_i, link_overvoltage_i};
			{q_uv, q_tohw, q_door} <= {input_undervoltage_fault_i,
				transformer_overheat_warning_i, door_open_warning_i};
			{q_ctrl_pwr, q_hv, q_link_ok, q_operable} <= {control_power_i, hv_power_i,
				cell_link_ok_i, operable_i};
		end
	end

	// Terminals come from pins, so two stages before any use
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mfi_meta <= 15'h0000;
			mfi_sync <= 15'h0000;
		end else begin
			mfi_meta <= mfi_i;
			mfi_sync <= mfi_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register write

	// Frequency settings may not exceed the maximum frequency
	assign wr_value = (wr_data_i[15:0] > max_freq) ? max_freq : wr_data_i[15:0];
	// Stall level pinned into its legal percent range
	assign wr_stall = (wr_data_i[31:8] != 24'h000000) ? `SOS_STALL_MAX :
		(wr_data_i[7:0] < `SOS_STALL_MIN) ? `SOS_STALL_MIN :
		(wr_data_i[7:0] > `SOS_STALL_MAX) ? `SOS_STALL_MAX : wr_data_i[7:0];

	// Output selections
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sel <= RST_SEL;
		end else if (wr_en_i && addr_i[4:3] == 2'h0) begin
			sel[addr_i[2:0]] <= wr_data_i[4:0];
		end
	end

	// Detection, protection and terminal settings
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			detect_frequency <= `SOS_RST_DET_FREQ;
			detect_bandwidth <= `SOS_RST_DET_BAND;
			max_freq <= `SOS_RST_MAX_FREQ;
			stall_level <= `SOS_RST_STALL_LEVEL;
			ol_level <= `SOS_RST_OL_LEVEL;
			motor_rated <= `SOS_RST_MOTOR_RATED;
			stall_dc_limit <= `SOS_RST_STALL_DC;
			oh_limit <= `SOS_RST_OH_LIMIT;
			estop_cfg <= `SOS_RST_ESTOP_CFG;
		end else if (wr_en_i) begin
			case (addr_i)
				`SOS_OFS_DET_FREQ: detect_frequency <= wr_value;
				`SOS_OFS_DET_BAND: detect_bandwidth <= wr_value;
				`SOS_OFS_MAX_FREQ: max_freq <= wr_data_i[15:0];
				`SOS_OFS_STALL_LEVEL: stall_level <= wr_stall;
				`SOS_OFS_OL_LEVEL: ol_level <= wr_data_i[15:0];
				`SOS_OFS_MOTOR_RATED: motor_rated <= wr_data_i[15:0];
				`SOS_OFS_STALL_DC: stall_dc_limit <= wr_data_i[15:0];
				`SOS_OFS_OH_LIMIT: oh_limit <= wr_data_i[15:0];
				`SOS_OFS_ESTOP_CFG: estop_cfg <= wr_data_i[4:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register read

	// Unmapped offsets read zero
	always_comb begin
		next_rd_data = 32'h00000000;
		if (addr_i[4:3] == 2'h0) begin
			next_rd_data = {27'h0000000, sel[addr_i[2:0]]};
		end else begin
			case (addr_i)
				`SOS_OFS_DET_FREQ: next_rd_data = {16'h0000, detect_frequency};
				`SOS_OFS_DET_BAND: next_rd_data = {16'h0000, detect_bandwidth};
				`SOS_OFS_MAX_FREQ: next_rd_data = {16'h0000, max_freq};
				`SOS_OFS_STALL_LEVEL: next_rd_data = {24'h000000, stall_level};
				`SOS_OFS_OL_LEVEL: next_rd_data = {16'h0000, ol_level};
				`SOS_OFS_MOTOR_RATED: next_rd_data = {16'h0000, motor_rated};
				`SOS_OFS_STALL_DC: next_rd_data = {16'h0000, stall_dc_limit};
				`SOS_OFS_OH_LIMIT: next_rd_data = {16'h0000, oh_limit};
				`SOS_OFS_ESTOP_CFG: next_rd_data = {27'h0000000, estop_cfg};
				`SOS_OFS_STATUS: next_rd_data = {23'h000000, emergency_stop_o, aux_o};
				`SOS_OFS_ITEMS: next_rd_data = {9'h000, items.item};
				default: next_rd_data = 32'h00000000;
			endcase
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_data_o <= 32'h00000000;
		end else begin
			rd_data_o <= rd_en_i ? next_rd_data : 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Item logic

	// Only deceleration without acceleration lowers the threshold
	sos_freq_cmp u_freq_cmp (
		.cmd_freq_i(q_cmd),
		.out_freq_i(q_out),
		.det_freq_i(detect_frequency),
		.det_band_i(detect_bandwidth),
		.decel_i(q_decel && !q_accel),
		.cmd_reached_o(fd_cmd),
		.target_reached_o(fd_target),
		.match_o(fd_match),
		.above_o(fd_above),
		.below_o(fd_below)
	);

	// Stall by current in percent of rated, or by link volts when slowing
	assign cur_pct = {8'h00, q_cur} * `SOS_PCT_SCALE;
	assign stall_limit = {8'h00, motor_rated} * {16'h0000, stall_level};
	assign stall_active = (q_decel && !q_accel) ? (q_dc > stall_dc_limit) : (cur_pct > stall_limit);

	// Item vector, bit index equals the item code
	always_comb begin
		items.item = 23'h000000;
		items.item[ITEM_CMD_REACHED] = fd_cmd;
		items.item[ITEM_TARGET_REACHED] = fd_target;
		items.item[ITEM_FREQ_MATCH] = fd_match;
		items.item[ITEM_ABOVE] = fd_above;
		items.item[ITEM_BELOW] = fd_below;
		items.item[ITEM_OL_WARN] = q_running && (q_cur > ol_level);
		items.item[ITEM_DRIVE_OL] = q_iol;
		items.item[ITEM_OVERCURRENT] = q_oct;
		items.item[ITEM_STALL] = q_running && stall_active;
		items.item[ITEM_LINK_OV] = q_ov;
		items.item[ITEM_UNDERVOLT] = q_uv;
		items.item[ITEM_OVERHEAT] = q_temp > oh_limit;
		items.item[ITEM_LOST_CMD] = q_lost;
		items.item[ITEM_RUN] = q_running && !q_brake && !q_bypass;
		items.item[ITEM_STOP] = !q_running;
		items.item[ITEM_STEADY] = q_running && !q_accel && !q_decel;
		items.item[ITEM_SPEED_SEARCH] = q_search;
		items.item[ITEM_READY] = q_ctrl_pwr;
		items.item[ITEM_FAN_RUN] = q_hv;
		items.item[ITEM_WARNING] = q_tohw || q_door;
		items.item[ITEM_NORMAL] = q_link_ok && q_operable;
		items.item[ITEM_MV_RUN] = q_running && !q_brake;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	// One selector per contact
	for (genvar g = 0; g < 8; g++) begin : g_aux
		sos_aux_out u_aux (
			.ref_clk_i(ref_clk_i),
			.reset_n_i(reset_n_i),
			.sel_i(sel[g]),
			.items(items.snk),
			.aux_o(aux_o[g])
		);
	end

	// Emergency stop from the chosen terminal; terminal codes past the last read off
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			emergency_stop_o <= 1'b0;
		end else begin
			emergency_stop_o <= estop_cfg[`SOS_ESTOP_EN_BIT] && (estop_cfg[3:0] < `SOS_TERM_COUNT)
				&& mfi_sync[estop_cfg[3:0]];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	AST_SEL_RESET: assert property (@(posedge ref_clk_i)
		$rose(reset_n_i) |-> sel[0] == ITEM_READY && sel[1] == ITEM_FAN_RUN
		&& sel[2] == ITEM_NORMAL && sel[3] == ITEM_RUN && sel[4] == ITEM_WARNING
		&& sel[5] == ITEM_NONE && sel[6] == ITEM_NONE && sel[7] == ITEM_NONE)
		else $error("output selections not at defaults after reset");

	AST_NONE_QUIET: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		sel[6] == ITEM_NONE |=> !aux_o[6])
		else $error("output with no selection is active");

	AST_CMD_REACH: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		sel[0] == ITEM_CMD_REACHED |=> aux_o[0] ==
		$past(((q_cmd > q_out) ? q_cmd - q_out : q_out - q_cmd) <= (detect_bandwidth >> 1)))
		else $error("command reached output wrong");

	AST_TARGET_REACH: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		items.item[ITEM_TARGET_REACHED] |-> items.item[ITEM_CMD_REACHED]
		&& items.item[ITEM_FREQ_MATCH])
		else $error("target reached without both conditions");

	AST_MATCH: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		items.item[ITEM_FREQ_MATCH] ==
		(((detect_frequency > q_out) ? detect_frequency - q_out : q_out - detect_frequency)
		<= (detect_bandwidth >> 1)))
		else $error("frequency match wrong");

	AST_ABOVE_DECEL: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(q_decel && !q_accel) |-> items.item[ITEM_ABOVE] ==
		(18'({q_out, 1'b0}) + 18'(detect_bandwidth) > 18'({detect_frequency, 1'b0})))
		else $error("above detection wrong while decelerating");

	AST_BELOW_ACCEL: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		!q_decel |-> items.item[ITEM_BELOW] == (q_out <= detect_frequency))
		else $error("below detection wrong at accel or constant speed");

	AST_FREQ_LIMIT: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		wr_en_i && addr_i == `SOS_OFS_DET_BAND |=> detect_bandwidth <= $past(max_freq))
		else $error("detection band above maximum frequency");

	AST_OVERLOAD: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		sel[1] == ITEM_OL_WARN && $past(!running_i, 1) |=> !aux_o[1])
		else $error("overload warning while stopped");

	AST_STALL_RANGE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		stall_level >= `SOS_STALL_MIN && stall_level <= `SOS_STALL_MAX)
		else $error("stall level outside its range");

	AST_RUN_HOLD: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(dc_brake_i || bypass_switch_i) ##1 sel[3] == ITEM_RUN |=> !aux_o[3])
		else $error("run output during braking or bypass");

	AST_MV_RUN: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		q_running && q_bypass && !q_brake |-> items.item[ITEM_MV_RUN])
		else $error("MV run dropped during bypass switchover");

	AST_ESTOP: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		emergency_stop_o |-> $past(estop_cfg[`SOS_ESTOP_EN_BIT])
		&& $past(mfi_sync[estop_cfg[3:0]]))
		else $error("emergency stop without its terminal");

	AST_LATENCY: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		sel[4] == ITEM_READY ##1 sel[4] == ITEM_READY |-> aux_o[4] == $past(control_power_i, 2))
		else $error("output not two edges behind its input");

endmodule : sos_top
`default_nettype wire

/* File: dv/sos_relay_model.sv */
// Relay contacts that the plant watches on the auxiliary outputs
`timescale 1ns/100ps
`default_nettype none
module sos_relay_model (
	// Clock
	input wire logic ref_clk_i,
	// Coil drive and contact state
	input wire logic [7:0] aux_i,
	output logic [7:0] contact_o
);
	// Contacts pick up one cycle after the coil, no bounce modelled
	always_ff @(posedge ref_clk_i) begin
		contact_o <= aux_i;
	end
endmodule : sos_relay_model
`default_nettype wire

/* File: dv/sos_top_tb.sv */
// Self-checking bench of the status output selector
`timescale 1ns/100ps
`default_nettype none
module sos_top_tb;
	import sos_pkg::*;
	localparam int DF = 256;
	localparam int BW = 64;
	localparam int OLV = 200;
	localparam int SDC = 300;
	localparam int OHL = 280;
	// Fixed selections that reach the checks guarding single outputs
	localparam logic [4:0] DSEL [8] = '{5'h01, 5'h06, 5'h02, 5'h0D, 5'h11, 5'h08, 5'h00, 5'h16};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] addr = '0;
	logic [31:0] wd = '0;
	logic we = 1'b0;
	logic re = 1'b0;
	logic pend = 1'b0;
	logic [31:0] rdat;
	logic [7:0] aux;
	logic es;
	logic [7:0] contact;
	logic [15:0] cf = '0, of = '0, cur = '0, dcv = '0, tmp = '0;
	logic [16:0] s = '0;
	logic [14:0] mfi = '0;
	logic [4:0] sel [8] = '{5'h11, 5'h13, 5'h14, 5'h0D, 5'h12, 5'h00, 5'h00, 5'h00};
	logic [4:0] ecfg = '0;
	logic [31:0] q [$];
	int bad_count = 0;
	int num_checks = 0;
	int seed = 22;
	sos_items_t it;
	logic [7:0] ea;
	logic ee;
	always #5 clk = ~clk;
	// Status bits: run acc dec brk byp ss lost dol oct ov uv tow door cp hv ok op
	sos_top i_sos_top (.ref_clk_i(clk), .reset_n_i(rst_n), .addr_i(addr), .wr_data_i(wd),
		.wr_en_i(we), .rd_en_i(re), .rd_data_o(rdat), .cmd_freq_i(cf), .out_freq_i(of),
		.out_current_i(cur), .cell_dc_volt_i(dcv), .cell_temp_i(tmp), .running_i(s[0]),
		.accel_i(s[1]), .decel_i(s[2]), .dc_brake_i(s[3]), .bypass_switch_i(s[4]),
		.speed_search_active_i(s[5]), .lost_cmd_i(s[6]), .drive_overload_i(s[7]),
		.overcurrent_fault_i(s[8]), .link_overvoltage_i(s[9]),
		.input_undervoltage_fault_i(s[10]), .transformer_overheat_warning_i(s[11]),
		.door_open_warning_i(s[12]), .control_power_i(s[13]), .hv_power_i(s[14]),
		.cell_link_ok_i(s[15]), .operable_i(s[16]), .mfi_i(mfi), .aux_o(aux),
		.emergency_stop_o(es));
	sos_relay_model i_sos_relay_model (.ref_clk_i(clk), .aux_i(aux), .contact_o(contact));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (e !== g) begin
			$display("[ERR] %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask : wr
	// Expected data is queued now, compared when the answer stands
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		q.push_back(e);
		@(posedge clk);
		re <= 1'b0;
	endtask : rd
	always @(posedge clk) begin
		if (pend) chk("rd_data", q.pop_front(), rdat);
		pend <= re;
	end
	function automatic int ad(input int a, input int b);
		return a > b ? a - b : b - a;
	endfunction : ad
	// Item vector worked out from the held inputs
	function automatic sos_items_t items_f();
		sos_items_t t;
		logic am;
		t = '0;
		am = !(s[2] && !s[1]);
		t[1] = 2 * ad(cf, of) <= BW;
		t[3] = 2 * ad(DF, of) <= BW;
		t[2] = t[1] && t[3];
		t[4] = am ? int'(of) >= DF : int'(of) > DF - BW / 2;
		t[5] = am ? int'(of) <= DF : int'(of) < DF - BW / 2;
		t[6] = s[0] && int'(cur) > OLV;
		t[7] = s[7];
		t[21] = s[8];
		t[8] = s[0] && (am ? int'(cur) * 100 > 100 * 100 : int'(dcv) > SDC);
		t[9] = s[9];
		t[10] = s[10];
		t[11] = int'(tmp) > OHL;
		t[12] = s[6];
		t[13] = s[0] && !s[3] && !s[4];
		t[14] = !s[0];
		t[15] = s[0] && !s[1] && !s[2];
		t[16] = s[5];
		t[17] = s[13];
		t[19] = s[14];
		t[18] = s[11] || s[12];
		t[20] = s[15] && s[16];
		t[22] = s[0] && !s[3];
		return t;
	endfunction : items_f
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++) rd(5'(i), {27'h0, sel[i]});
		rd(5'h1F, 32'h0);
		rd(5'h0B, 32'h64);
		wr(5'h0B, 32'hA);
		rd(5'h0B, 32'h1E);
		wr(5'h0B, 32'hC8);
		rd(5'h0B, 32'h96);
		wr(5'h0B, 32'h64);
		wr(5'h0A, 32'h100);
		wr(5'h08, 32'h200);
		rd(5'h08, 32'h100);
		wr(5'h0A, 32'h1770);
		wr(5'h08, DF);
		wr(5'h09, BW);
		wr(5'h0C, OLV);
		wr(5'h0E, SDC);
		wr(5'h0F, OHL);
		// First pass keeps the reset selections, every eighth pass uses fixed ones
		for (int n = 0; n < 80; n++) begin
			if (n > 0) begin
				for (int k = 0; k < 8; k++) begin
					sel[k] = (n % 8 == 1) ? DSEL[k] : 5'($random(seed));
					wr(5'(k), {27'h0, sel[k]});
				end
			end
			ecfg = 5'($random(seed));
			wr(5'h10, {27'h0, ecfg});
			@(posedge clk);
			s <= 17'($random(seed));
			mfi <= 15'($random(seed));
			of <= 16'h00C0 + 16'($random(seed) & 32'h7F);
			cf <= 16'h00C0 + 16'($random(seed) & 32'h7F);
			cur <= 16'($random(seed) & 32'h1FF);
			dcv <= 16'($random(seed) & 32'h1FF);
			tmp <= 16'($random(seed) & 32'h1FF);
			repeat (5) @(posedge clk);
			it = items_f();
			for (int k = 0; k < 8; k++) ea[k] = sel[k] <= 5'h16 ? it[sel[k]] : 1'b0;
			ee = ecfg[4] && ecfg[3:0] != 4'hF && mfi[ecfg[3:0]];
			rd(5'h12, {9'h0, it});
			rd(5'h11, {23'h0, ee, ea});
			chk("contacts", {24'h0, ea}, {24'h0, contact});
			chk("estop", {31'h0, ee}, {31'h0, es});
		end
		// Reset in mid-run clears the outputs and restores the default selections
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		chk("outputs_in_reset", 32'h0, {23'h0, es, aux});
		rst_n <= 1'b1;
		sel = '{5'h11, 5'h13, 5'h14, 5'h0D, 5'h12, 5'h00, 5'h00, 5'h00};
		for (int i = 0; i < 8; i++) rd(5'(i), {27'h0, sel[i]});
		repeat (3) @(posedge clk);
		end_of_test();
	end
	// Watchdog well beyond the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		end_of_test();
	end
endmodule : sos_top_tb
`default_nettype wire
